// ---- design/psr_sram.sv ----
`timescale 1ns/1ps
module psr_sram
  import psr_pkg::*;
(
  input  wire logic                 CORE_CLK,
  input  wire logic                 RESETN,
  input  wire logic                 CLK_QUAL_N,
  input  wire logic [ADDR_W-1:0]    ADDR,
  input  wire logic                 WRITE_N,
  input  wire logic [LANES-1:0]     BYTE_LANE_WRITE_SEL_N,
  input  wire logic                 ADVANCE_OR_LOAD,
  input  wire logic                 CHIP_SELECT_A_N,
  input  wire logic                 CHIP_SELECT_B,
  input  wire logic                 CHIP_SELECT_C_N,
  input  wire logic                 OUTPUT_EN_N,
  input  wire logic                 BURST_LINEAR,
  input  wire logic [DATA_W-1:0]    DATA_IN,
  input  wire logic [PAR_W-1:0]     PARITY_IO_IN,
  output logic      [DATA_W-1:0]    DATA_OUT,
  output logic      [PAR_W-1:0]     PARITY_IO_OUT,
  output logic                      DATA_OE
);

  logic                 qual;
  logic                 chip_sel;
  psr_cmd_t             cmd_next;
  logic [BURST_W-1:0]   cnt_next;
  psr_cmd_t             s1_reg;
  psr_cmd_t             s2_reg;
  psr_cmd_t             s3_reg;
  psr_word_t            wdata_reg;
  psr_word_t            dout_reg;
  psr_word_t            rd_word;
  psr_word_t            pin_word;
  logic                 drive_reg;
  logic                 burst_live_reg;
  logic                 burst_wr_reg;
  logic [ADDR_W-1:0]    base_reg;
  logic [BURST_W-1:0]   cnt_reg;
  psr_word_t            mem [WORDS];

  // burst order of the two low address bits
  function automatic logic [BURST_W-1:0] burst_low(input logic [BURST_W-1:0] base,
                                                   input logic [BURST_W-1:0] cnt,
                                                   input logic linear);
    burst_low = linear ? base + cnt : base ^ cnt;
  endfunction

  // lane merge keeps the unselected byte and its parity bit
  function automatic psr_word_t lane_merge(input psr_word_t old_w, input psr_word_t new_w,
                                           input logic [LANES-1:0] lanes);
    psr_word_t m;
    m = old_w;
    for (int i = 0; i < LANES; i++) begin
      if (lanes[i]) begin
        m.data[i*LANE_W +: LANE_W] = new_w.data[i*LANE_W +: LANE_W];
        m.par[i] = new_w.par[i];
      end
    end
    lane_merge = m;
  endfunction

  assign qual     = ~CLK_QUAL_N;
  assign chip_sel = ~CHIP_SELECT_A_N & CHIP_SELECT_B & ~CHIP_SELECT_C_N;
  assign pin_word = '{par: PARITY_IO_IN, data: DATA_IN};

  always_comb begin
    cmd_next       = CMD_IDLE;
    cnt_next       = BURST_RST;
    cmd_next.lanes = ~BYTE_LANE_WRITE_SEL_N;
    if (ADVANCE_OR_LOAD) begin
      // advance after a deselect stays deselected
      cnt_next       = cnt_reg + BURST_ONE;
      cmd_next.valid = burst_live_reg;
      cmd_next.write = burst_wr_reg;
      cmd_next.addr  = {base_reg[ADDR_W-1:BURST_W],
                        burst_low(base_reg[BURST_W-1:0], cnt_next, BURST_LINEAR)};
    end else begin
      cmd_next.valid = chip_sel;
      cmd_next.write = ~WRITE_N;
      cmd_next.addr  = ADDR;
    end
  end

  // burst bookkeeping
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      burst_live_reg <= 1'b0;
      burst_wr_reg   <= 1'b0;
      base_reg       <= '0;
      cnt_reg        <= BURST_RST;
    end else if (qual) begin
      cnt_reg <= cnt_next;
      if (!ADVANCE_OR_LOAD) begin
        burst_live_reg <= chip_sel;
        burst_wr_reg   <= ~WRITE_N;
        base_reg       <= ADDR;
      end
    end
  end

  // command pipeline, one new command every qualified edge
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s1_reg <= CMD_IDLE;
      s2_reg <= CMD_IDLE;
    end else if (qual) begin
      s1_reg <= cmd_next;
      s2_reg <= s1_reg;
    end
  end

  // write data arrives two edges after its command
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s3_reg    <= CMD_IDLE;
      wdata_reg <= WORD_ZERO;
    end else if (qual) begin
      s3_reg       <= s2_reg;
      s3_reg.valid <= s2_reg.valid & s2_reg.write;
      wdata_reg    <= pin_word;
    end
  end

  // self-timed array write, one edge after the data is latched
  always_ff @(posedge CORE_CLK) begin
    if (qual && s3_reg.valid) begin
      mem[s3_reg.addr] <= lane_merge(mem[s3_reg.addr], wdata_reg, s3_reg.lanes);
    end
  end

  // a write still in flight must be seen by a read right behind it
  always_comb begin
    rd_word = mem[s1_reg.addr];
    if (s3_reg.valid && s3_reg.addr == s1_reg.addr) begin
      rd_word = lane_merge(rd_word, wdata_reg, s3_reg.lanes);
    end
    // newest write has its data on the pins at this same edge
    if (s2_reg.valid && s2_reg.write && s2_reg.addr == s1_reg.addr) begin
      rd_word = lane_merge(rd_word, pin_word, s2_reg.lanes);
    end
  end

  // read slot matches the write data slot, so no turnaround gap
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      dout_reg  <= WORD_ZERO;
      drive_reg <= 1'b0;
    end else if (qual) begin
      drive_reg <= s1_reg.valid & ~s1_reg.write;
      if (s1_reg.valid && !s1_reg.write) begin
        dout_reg <= rd_word;
      end
    end
  end

  assign DATA_OUT      = dout_reg.data;
  assign PARITY_IO_OUT = dout_reg.par;
  // async gate is the one output not straight from a flop
  assign DATA_OE       = drive_reg & ~OUTPUT_EN_N;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  a_input_capture: assert property (
    qual && !ADVANCE_OR_LOAD && chip_sel |=> s1_reg.valid && s1_reg.addr == $past(ADDR))
    else $error("load address not captured");

  a_stall_hold: assert property (
    !qual |=> $stable(s1_reg) && $stable(s2_reg) && $stable(dout_reg) && $stable(drive_reg))
    else $error("state moved while qualifier high");

  a_read_latency: assert property (
    qual && cmd_next.valid && !cmd_next.write ##1 qual [*2] |-> drive_reg)
    else $error("read data not driven after two edges");

  a_write_tristate: assert property (
    qual && cmd_next.valid && cmd_next.write ##1 qual [*2] |-> !drive_reg)
    else $error("drivers on in write data cycle");

  a_deselect_idle: assert property (
    qual && !ADVANCE_OR_LOAD && !chip_sel |=> !s1_reg.valid)
    else $error("deselect started an access");

  a_oe_gate: assert property (
    OUTPUT_EN_N |-> !DATA_OE)
    else $error("drivers on with output enable off");

  a_back_to_back: assert property (
    qual && cmd_next.valid ##1 qual && cmd_next.valid |=> s1_reg.valid && $past(s1_reg.valid))
    else $error("back to back command dropped");

  a_burst_linear: assert property (
    qual && ADVANCE_OR_LOAD && BURST_LINEAR && s1_reg.valid && burst_live_reg
    |=> s1_reg.addr == {$past(s1_reg.addr[ADDR_W-1:BURST_W]),
                        $past(s1_reg.addr[BURST_W-1:0]) + BURST_ONE})
    else $error("linear burst did not step by one");

  a_advance_keep: assert property (
    qual && ADVANCE_OR_LOAD |=> s1_reg.write == $past(burst_wr_reg)
                                && s1_reg.valid == $past(burst_live_reg))
    else $error("advance changed operation type");

  a_turnaround: assert property (
    qual && s1_reg.valid && !s1_reg.write ##1 qual && !s1_reg.valid |=> !drive_reg)
    else $error("drivers left on after read");

endmodule // psr_sram

// ---- design/psr_pkg.sv ----
package psr_pkg;

  localparam int ADDR_W      = 18;
  localparam int DATA_W      = 16;
  localparam int PAR_W       = 2;
  localparam int LANES       = 2;
  localparam int LANE_W      = 8;
  localparam int WORD_W      = DATA_W + PAR_W;
  localparam int WORDS       = 262144;
  localparam int BURST_W     = 2;
  localparam int READ_LAT    = 2;
  localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;

  typedef struct packed {
    logic                valid;
    logic                write;
    logic [ADDR_W-1:0]   addr;
    logic [LANES-1:0]    lanes;
  } psr_cmd_t;

  typedef struct packed {
    logic [PAR_W-1:0]    par;
    logic [DATA_W-1:0]   data;
  } psr_word_t;

  localparam psr_cmd_t  CMD_IDLE  = '{valid: 1'b0, write: 1'b0, addr: 18'h0, lanes: 2'h0};
  localparam psr_word_t WORD_ZERO = '{par: 2'h0, data: 16'h0};

endpackage

// ---- tb/psr_ctrl_model.sv ----
`timescale 1ns/1ps
module psr_ctrl_model
  import psr_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      drive,
  input  wire psr_word_t wword,
  input  wire logic      dut_oe,
  input  wire psr_word_t dut_word,
  output psr_word_t      bus
);
  psr_word_t last_reg;
  // released wire shows inverse of last level, so stale data never matches
  always_comb begin
    if (dut_oe) begin
      bus = dut_word;
    end else if (drive) begin
      bus = wword;
    end else begin
      bus = ~last_reg;
    end
  end
  always_ff @(posedge clk) begin
    last_reg <= bus;
  end
endmodule // psr_ctrl_model

// ---- tb/psr_sram_tb_top.sv ----
`timescale 1ns/1ps
module psr_sram_tb_top
  import psr_pkg::*;
;
  typedef struct packed {
    logic adv; logic wr; logic lin; logic [2:0] sel;
    logic [17:0] a; logic [1:0] ln; logic [17:0] d;
  } psr_row_t;
  localparam int NR = 15;
  localparam psr_row_t IDLE = '{1'h0,1'h0,1'h1,3'h6,18'h0,2'h3,18'h0};
  psr_row_t rows [NR] = '{
    '{1'h0,1'h1,1'h1,3'h2,18'h10,2'h0,18'h0a5c3},
    '{1'h0,1'h1,1'h1,3'h2,18'h11,2'h0,18'h01234},
    '{1'h0,1'h0,1'h1,3'h2,18'h10,2'h0,18'h0a5c3},
    '{1'h0,1'h1,1'h1,3'h2,18'h10,2'h2,18'h3ffff},
    '{1'h0,1'h0,1'h1,3'h2,18'h10,2'h0,18'h1a5ff},
    '{1'h0,1'h0,1'h1,3'h6,18'h10,2'h0,18'h0},
    '{1'h0,1'h1,1'h1,3'h0,18'h10,2'h0,18'h0},
    '{1'h0,1'h1,1'h1,3'h3,18'h10,2'h0,18'h0},
    '{1'h0,1'h1,1'h1,3'h2,18'h13,2'h0,18'h2beef},
    '{1'h0,1'h0,1'h1,3'h2,18'h13,2'h0,18'h2beef},
    '{1'h1,1'h0,1'h1,3'h2,18'h0,2'h0,18'h1a5ff},
    '{1'h1,1'h0,1'h1,3'h2,18'h0,2'h0,18'h01234},
    '{1'h0,1'h0,1'h0,3'h2,18'h11,2'h0,18'h01234},
    '{1'h1,1'h0,1'h0,3'h2,18'h0,2'h0,18'h1a5ff},
    '{1'h1,1'h0,1'h0,3'h2,18'h0,2'h0,18'h2beef}};
  logic CORE_CLK, RESETN, CLK_QUAL_N, WRITE_N, ADVANCE_OR_LOAD, OUTPUT_EN_N;
  logic CHIP_SELECT_A_N, CHIP_SELECT_B, CHIP_SELECT_C_N, BURST_LINEAR, DATA_OE, drv;
  logic [17:0] ADDR;
  logic [1:0]  BYTE_LANE_WRITE_SEL_N, rp;
  logic [15:0] rd;
  psr_word_t   ww, bus;
  int          errors, check_count;
  psr_sram u_dut (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .CLK_QUAL_N(CLK_QUAL_N),
    .ADDR(ADDR), .WRITE_N(WRITE_N), .BYTE_LANE_WRITE_SEL_N(BYTE_LANE_WRITE_SEL_N),
    .ADVANCE_OR_LOAD(ADVANCE_OR_LOAD), .CHIP_SELECT_A_N(CHIP_SELECT_A_N),
    .CHIP_SELECT_B(CHIP_SELECT_B), .CHIP_SELECT_C_N(CHIP_SELECT_C_N),
    .OUTPUT_EN_N(OUTPUT_EN_N), .BURST_LINEAR(BURST_LINEAR), .DATA_IN(bus.data),
    .PARITY_IO_IN(bus.par), .DATA_OUT(rd), .PARITY_IO_OUT(rp), .DATA_OE(DATA_OE));
  psr_ctrl_model u_ctrl (.clk(CORE_CLK), .drive(drv), .wword(ww), .dut_oe(DATA_OE),
    .dut_word({rp, rd}), .bus(bus));
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic put(input psr_row_t r);
    ADVANCE_OR_LOAD <= r.adv;
    WRITE_N <= !r.wr;
    BURST_LINEAR <= r.lin;
    {CHIP_SELECT_A_N, CHIP_SELECT_B, CHIP_SELECT_C_N} <= r.sel;
    ADDR <= r.a;
    BYTE_LANE_WRITE_SEL_N <= r.ln;
  endtask
  initial begin
    CORE_CLK = 0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end
  initial begin
    repeat (2000) @(posedge CORE_CLK);
    errors++;
    tally_and_finish();
  end
  initial begin
    RESETN = 0;
    CLK_QUAL_N = 0;
    OUTPUT_EN_N = 0;
    drv = 0;
    ww = WORD_ZERO;
    put(IDLE);
    repeat (20) @(posedge CORE_CLK);
    RESETN <= 1;
    for (int i = 0; i < NR + 3; i++) begin
      @(posedge CORE_CLK);
      put(i < NR ? rows[i] : IDLE);
      drv <= 0;
      if (i >= 2 && i < NR + 2) begin
        drv <= rows[i-2].wr && rows[i-2].sel == 3'h2;
        ww <= rows[i-2].d;
      end
      #1;
      if (i >= 2 && i < NR + 2) begin
        check({17'h0, DATA_OE}, {17'h0, !rows[i-2].wr && rows[i-2].sel == 3'h2});
        check({17'h0, DATA_OE & drv}, 18'h0);
        if (!rows[i-2].wr && rows[i-2].sel == 3'h2)
          check(bus, rows[i-2].d);
      end
    end
    @(posedge CORE_CLK);
    put(rows[9]);
    @(posedge CORE_CLK);
    put(IDLE);
    CLK_QUAL_N <= 1;
    // three ignored edges stretch the pipeline
    @(posedge CORE_CLK);
    #1 check({17'h0, DATA_OE}, 18'h0);
    repeat (2) @(posedge CORE_CLK);
    CLK_QUAL_N <= 0;
    @(posedge CORE_CLK);
    #1 check(bus, 18'h2beef);
    OUTPUT_EN_N = 1;
    #1 check({17'h0, DATA_OE}, 18'h0);
    OUTPUT_EN_N = 0;
    #1 check({17'h0, DATA_OE}, 18'h1);
    RESETN = 0;
    #1 check({rp, rd}, 18'h0);
    check({17'h0, DATA_OE}, 18'h0);
    tally_and_finish();
  end
endmodule // psr_sram_tb_top
